// file: rtl/thermal_pkg.sv
// Shared constants, types and timing for the thermal sensor serial slave
package thermal_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int UPDATE_MS       = 125;
  localparam int UPDATE_CYCLES   = UPDATE_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_MS      = 25;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W           = 22;

  // ----------------------------------------
  // Register pointer locations
  // ----------------------------------------
  localparam logic [2:0] REG_CAPABILITY = 3'h0;
  localparam logic [2:0] REG_CONFIG     = 3'h1;
  localparam logic [2:0] REG_UPPER      = 3'h2;
  localparam logic [2:0] REG_LOWER      = 3'h3;
  localparam logic [2:0] REG_CRITICAL   = 3'h4;
  localparam logic [2:0] REG_TEMP       = 3'h5;
  localparam logic [2:0] REG_MANUF      = 3'h6;
  localparam logic [2:0] REG_DEVICE     = 3'h7;
  localparam logic [2:0] PTR_RST        = 3'h0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CAPABILITY_RST = 16'h002f;
  localparam logic [15:0] TRIP_RST       = 16'h0000;
  localparam logic [9:0]  TEMP_RST       = 10'h000;

  // ----------------------------------------
  // Configuration word bit positions
  // ----------------------------------------
  localparam int CFG_INT_MODE_BIT  = 0;
  localparam int CFG_CRIT_ONLY_BIT = 2;
  localparam int CFG_EVT_EN_BIT    = 3;
  localparam int CFG_INT_CLR_BIT   = 5;
  localparam int CFG_TMO_DIS_BIT   = 7;

  // ----------------------------------------
  // Temperature word field positions
  // ----------------------------------------
  localparam int TW_CRIT_BIT  = 15;
  localparam int TW_ABOVE_BIT = 14;
  localparam int TW_BELOW_BIT = 13;
  localparam int TW_LSB_POS   = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [2:0] strap;
  } pins_s;

  typedef struct packed {
    logic tmo_dis;
    logic evt_en;
    logic crit_only;
    logic int_mode;
  } cfg_s;

  localparam pins_s PINS_RST = '{scl: 1'b1, sda: 1'b1, strap: 3'h0};
  localparam cfg_s  CFG_RST  = '{tmo_dis: 1'b0, evt_en: 1'b0, crit_only: 1'b0, int_mode: 1'b0};

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WR_MSB,
    ST_WR_LSB,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } link_state_e;

endpackage

// file: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for the serial pins and straps
module pin_sync
  import thermal_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  input  wire pins_s pins_i,
  output pins_s      pins_o
);

  pins_s s1_reg;
  pins_s s2_reg;
  pins_s s3_reg;
  pins_s filt_reg;

  // ----------------------------------------
  // Sampling chain
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_reg <= PINS_RST;
      s2_reg <= PINS_RST;
      s3_reg <= PINS_RST;
    end else begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ----------------------------------------
  // Change accepted when stages two and three agree
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      filt_reg <= PINS_RST;
    end else begin
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end

  assign pins_o = filt_reg;

endmodule

// file: rtl/temp_update.sv
// Periodic temperature sample timer
module temp_update
  import thermal_pkg::*;
#(
  parameter int PERIOD = UPDATE_CYCLES
)
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic restart_i,
  output logic      sample_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic             sample_reg;

  // ----------------------------------------
  // Period counter
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_reg    <= '0;
      sample_reg <= 1'b0;
    end else if (restart_i || cnt_reg == CNT_W'(PERIOD - 1)) begin
      cnt_reg    <= '0;
      sample_reg <= 1'b1;
    end else begin
      cnt_reg    <= cnt_reg + CNT_W'(1);
      sample_reg <= 1'b0;
    end
  end

  assign sample_o = sample_reg;

endmodule

// file: rtl/thermal_sensor_serial_slave.sv
// Two-wire serial slave of a module temperature sensor with event output
// Behaviour
// - Slave address is the type code above three strap bits.
// - Strap bit2 is the address MSB of three, bit0 just above R/W.
// - Temperature value refreshed at least eight times per second.
// - Temperature held in a latch; reads never wait for conversion.
// - Configuration registers take defaults at reset before any access.
// - Pointer resets to location zero, the capability register.
// - Pointer keeps its value across reads until rewritten.
// - Register write carries two data bytes after the pointer.
// - Address-only read returns two bytes from the pointed register.
// - Bytes shift most significant bit first both ways.
// - Master ack or nack accepted; nack ends the read.
// - Next measurement completes within 125 ms after a read ends.
// - Device never drives the serial clock; it only samples it.
// - Event output is open drain, pulled low when active.
// - Event fires above critical limit or outside the alarm window.
// - Event can be restricted to the critical condition only.
// - Event works in comparator or interrupt mode by configuration.
// - Temperature is a 10-bit code in 0.25 degree steps.
// - Clock low beyond 25 ms resets the interface; enabled by default.
module thermal_sensor_serial_slave
  import thermal_pkg::*;
#(
  parameter int          UPDATE_CYCLES_P  = UPDATE_CYCLES,
  parameter int          TIMEOUT_CYCLES_P = TIMEOUT_CYCLES,
  // Identification values are arbitrary
  parameter logic [3:0]  DEVICE_TYPE_CODE = 4'h9,
  parameter logic [15:0] MANUF_ID         = 16'h1234,
  parameter logic [15:0] DEVICE_ID        = 16'h5678
)
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_strap_bit0_i,
  input  wire logic       addr_strap_bit1_i,
  input  wire logic       addr_strap_bit2_i,
  input  wire logic [9:0] temp_code_i,
  output logic            event_o,
  output logic            event_oe_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  pins_s        pins_raw;
  pins_s        pins_f;
  logic         scl_d_reg;
  logic         sda_d_reg;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic [6:0]   own_addr;

  link_state_e  state_reg;
  link_state_e  ack_next_reg;
  logic [7:0]   shreg_reg;
  logic [3:0]   bit_cnt_reg;
  logic [2:0]   ptr_reg;
  logic [7:0]   msb_reg;
  logic [15:0]  rd_word_reg;
  logic         byte_sel_reg;
  logic         m_ack_reg;
  logic         sda_oe_reg;
  logic         sda_o_reg;
  logic         read_done_reg;
  logic         wr_strobe_reg;
  logic [15:0]  wr_data_reg;

  cfg_s         cfg_reg;
  logic [15:0]  upper_reg;
  logic [15:0]  lower_reg;
  logic [15:0]  crit_reg;
  logic [9:0]   temp_reg;
  logic         sample;

  logic [CNT_W-1:0] tmo_cnt_reg;
  logic         tmo_hit;

  logic signed [10:0] temp_q;
  logic         cond_above;
  logic         cond_below;
  logic         cond_crit;
  logic         evt_cond;
  logic         cond_d_reg;
  logic         sticky_reg;
  logic         int_clr;
  logic         event_oe_reg;
  logic         event_o_reg;
  logic [15:0]  temp_word;
  logic [15:0]  cfg_word;
  logic [15:0]  cur_word;

  function automatic logic signed [10:0] deg_q(input logic [15:0] w);
    deg_q = signed'(w[12:2]);
  endfunction

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  // Clock, data and strap inputs
  assign pins_raw = '{scl: scl_i, sda: sda_i, strap: {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i}};

  pin_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pins_i  (pins_raw),
    .pins_o  (pins_f)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= pins_f.scl;
      sda_d_reg <= pins_f.sda;
    end
  end

  assign scl_rise  = pins_f.scl & ~scl_d_reg;
  assign scl_fall  = ~pins_f.scl & scl_d_reg;
  assign start_det = pins_f.scl & scl_d_reg & sda_d_reg & ~pins_f.sda;
  assign stop_det  = pins_f.scl & scl_d_reg & ~sda_d_reg & pins_f.sda;

  // Own address from type code and straps
  assign own_addr = {DEVICE_TYPE_CODE, pins_f.strap[2], pins_f.strap[1], pins_f.strap[0]};

  // ----------------------------------------
  // Clock-low timeout
  // ----------------------------------------
  // Low clock counter
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tmo_cnt_reg <= '0;
    end else if (state_reg == ST_IDLE || pins_f.scl || tmo_hit) begin
      tmo_cnt_reg <= '0;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + CNT_W'(1);
    end
  end

  assign tmo_hit = !cfg_reg.tmo_dis && tmo_cnt_reg == CNT_W'(TIMEOUT_CYCLES_P - 1);

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  assign temp_word = {cond_crit, cond_above, cond_below, temp_reg[9], temp_reg, 2'b00};

  always_comb begin
    cfg_word                    = 16'h0000;
    cfg_word[CFG_INT_MODE_BIT]  = cfg_reg.int_mode;
    cfg_word[CFG_CRIT_ONLY_BIT] = cfg_reg.crit_only;
    cfg_word[CFG_EVT_EN_BIT]    = cfg_reg.evt_en;
    cfg_word[CFG_TMO_DIS_BIT]   = cfg_reg.tmo_dis;
  end

  always_comb begin
    case (ptr_reg)
      REG_CAPABILITY: cur_word = CAPABILITY_RST;
      REG_CONFIG:     cur_word = cfg_word;
      REG_UPPER:      cur_word = upper_reg;
      REG_LOWER:      cur_word = lower_reg;
      REG_CRITICAL:   cur_word = crit_reg;
      REG_TEMP:       cur_word = temp_word;
      REG_MANUF:      cur_word = MANUF_ID;
      default:        cur_word = DEVICE_ID;
    endcase
  end

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      ack_next_reg  <= ST_IDLE;
      shreg_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      ptr_reg       <= PTR_RST;
      msb_reg       <= 8'h00;
      rd_word_reg   <= 16'h0000;
      byte_sel_reg  <= 1'b0;
      m_ack_reg     <= 1'b0;
      sda_oe_reg    <= 1'b0;
      read_done_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_data_reg   <= 16'h0000;
    end else begin
      read_done_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      if (tmo_hit) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg  <= 1'b0;
      end else if (stop_det) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WR_MSB, ST_WR_LSB: begin
            if (scl_rise) begin
              shreg_reg   <= {shreg_reg[6:0], pins_f.sda};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_ACK;
              sda_oe_reg  <= 1'b1;
              case (state_reg)
                ST_ADDR: begin
                  if (shreg_reg[7:1] != own_addr) begin
                    state_reg  <= ST_IGNORE;
                    sda_oe_reg <= 1'b0;
                  end else if (shreg_reg[0]) begin
                    ack_next_reg <= ST_TX;
                    rd_word_reg  <= cur_word;
                  end else begin
                    ack_next_reg <= ST_PTR;
                  end
                end
                ST_PTR: begin
                  ptr_reg      <= shreg_reg[2:0];
                  ack_next_reg <= ST_WR_MSB;
                end
                ST_WR_MSB: begin
                  msb_reg      <= shreg_reg;
                  ack_next_reg <= ST_WR_LSB;
                end
                default: begin
                  wr_strobe_reg <= 1'b1;
                  wr_data_reg   <= {msb_reg, shreg_reg};
                  ack_next_reg  <= ST_IGNORE;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_reg   <= ack_next_reg;
              bit_cnt_reg <= 4'h0;
              if (ack_next_reg == ST_TX) begin
                shreg_reg    <= rd_word_reg[15:8];
                sda_oe_reg   <= ~rd_word_reg[15];
                byte_sel_reg <= 1'b0;
              end else begin
                sda_oe_reg <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_MACK;
              end else begin
                sda_oe_reg  <= ~shreg_reg[6];
                shreg_reg   <= {shreg_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              m_ack_reg <= ~pins_f.sda;
            end else if (scl_fall) begin
              if (m_ack_reg) begin
                bit_cnt_reg  <= 4'h0;
                byte_sel_reg <= ~byte_sel_reg;
                state_reg    <= ST_TX;
                if (byte_sel_reg) begin
                  shreg_reg  <= rd_word_reg[15:8];
                  sda_oe_reg <= ~rd_word_reg[15];
                end else begin
                  shreg_reg  <= rd_word_reg[7:0];
                  sda_oe_reg <= ~rd_word_reg[7];
                end
              end else begin
                state_reg     <= ST_IGNORE;
                read_done_reg <= 1'b1;
              end
            end
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Data pin level is always low
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register file and temperature latch
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_reg   <= CFG_RST;
      upper_reg <= TRIP_RST;
      lower_reg <= TRIP_RST;
      crit_reg  <= TRIP_RST;
    end else if (wr_strobe_reg) begin
      case (ptr_reg)
        REG_CONFIG: begin
          cfg_reg.int_mode  <= wr_data_reg[CFG_INT_MODE_BIT];
          cfg_reg.crit_only <= wr_data_reg[CFG_CRIT_ONLY_BIT];
          cfg_reg.evt_en    <= wr_data_reg[CFG_EVT_EN_BIT];
          cfg_reg.tmo_dis   <= wr_data_reg[CFG_TMO_DIS_BIT];
        end
        REG_UPPER:    upper_reg <= wr_data_reg;
        REG_LOWER:    lower_reg <= wr_data_reg;
        REG_CRITICAL: crit_reg  <= wr_data_reg;
        default:      cfg_reg   <= cfg_reg;
      endcase
    end
  end

  // Periodic refresh, restarted at read end
  temp_update #(
    .PERIOD (UPDATE_CYCLES_P)
  ) u_update (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .restart_i (read_done_reg),
    .sample_o  (sample)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      temp_reg <= TEMP_RST;
    end else if (sample) begin
      temp_reg <= temp_code_i;
    end
  end

  // ----------------------------------------
  // Event output
  // ----------------------------------------
  assign temp_q     = signed'({temp_reg[9], temp_reg});
  assign cond_above = temp_q > deg_q(upper_reg);
  assign cond_below = temp_q < deg_q(lower_reg);
  assign cond_crit  = temp_q > deg_q(crit_reg);
  assign evt_cond   = cfg_reg.crit_only ? cond_crit : (cond_above | cond_below | cond_crit);
  assign int_clr    = wr_strobe_reg && ptr_reg == REG_CONFIG && wr_data_reg[CFG_INT_CLR_BIT];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cond_d_reg   <= 1'b0;
      sticky_reg   <= 1'b0;
      event_oe_reg <= 1'b0;
      event_o_reg  <= 1'b0;
    end else begin
      cond_d_reg  <= evt_cond;
      event_o_reg <= 1'b0;
      // Crossing sets sticky; set wins over clear
      if (evt_cond != cond_d_reg) begin
        sticky_reg <= 1'b1;
      end else if (int_clr) begin
        sticky_reg <= 1'b0;
      end
      // Mode select, pull low when active
      event_oe_reg <= cfg_reg.evt_en & (cfg_reg.int_mode ? sticky_reg : evt_cond);
    end
  end

  assign sda_o      = sda_o_reg;
  assign sda_oe_o   = sda_oe_reg;
  assign event_o    = event_o_reg;
  assign event_oe_o = event_oe_reg;

endmodule

// file: dv/thermal_monitor.sv
// Port-level checks of the thermal sensor serial slave
module thermal_monitor
  import thermal_pkg::*;
#(
  parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic event_o,
  input wire logic event_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [22:0] low_cnt;
  logic        bus_seen;

  // Cycles the serial clock has been low
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || scl_i) low_cnt <= '0;
    else if (low_cnt != '1) low_cnt <= low_cnt + 1'b1;
  end

  // Any bus activity since reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) bus_seen <= 1'b0;
    else if (!scl_i) bus_seen <= 1'b1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !sda_oe_o && !event_oe_o)
    else $error("outputs driven after reset");
  a_pins_only_pull: assert property (!sda_o && !event_o)
    else $error("open-drain pin driven high");
  a_sda_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  a_answer_after_fall: assert property ($rose(sda_oe_o) |-> low_cnt inside {[2:8]})
    else $error("data driven out of the clock low phase");
  a_bit_held: assert property ($rose(sda_oe_o) |-> sda_oe_o [*5])
    else $error("driven bit released too early");
  a_timeout_release: assert property (low_cnt > TIMEOUT_CYCLES_P + 10 |-> !sda_oe_o)
    else $error("bus held past clock-low timeout");
  a_event_disabled: assert property (!bus_seen |-> !event_oe_o)
    else $error("event active before configuration");
  a_stop_releases: assert property (scl_i && $rose(sda_i) |=> !sda_oe_o [*8])
    else $error("data driven after stop");

  c_ack: cover property ($rose(sda_oe_o));
  c_event: cover property ($rose(event_oe_o));
  c_timeout: cover property (low_cnt > TIMEOUT_CYCLES_P);
endmodule

// file: dv/serial_master_model.sv
// Behavioural two-wire bus master
module serial_master_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic start();
    tick(1);
    sda_oe_o = 1'b0;
    tick(7);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_oe_o = ~b;
    tick(5);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ai, ao);
  endtask

  task automatic stop();
    tick(1);
    sda_oe_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b0;
    tick(8);
  endtask
endmodule

// file: dv/thermal_sensor_serial_slave_tb.sv
// Self-checking bench of the thermal sensor serial slave
module thermal_sensor_serial_slave_tb
  import thermal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UPD = 200;
  localparam int TMO = 2000;
  // Arbitrary type code
  localparam logic [3:0] TYPE = 4'h9;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [9:0] temp = 10'h000;
  logic       m_scl, m_oe, sda_o, sda_oe_o, event_o, event_oe_o;
  wire        sda = ~(m_oe | sda_oe_o);
  int         fail_count = 0;
  int         n_compared = 0;
  int         seed = 53;

  thermal_sensor_serial_slave #(.UPDATE_CYCLES_P(UPD), .TIMEOUT_CYCLES_P(TMO), .DEVICE_TYPE_CODE(TYPE))
    i_thermal_sensor_serial_slave (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(m_scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit2_i(strap[2]), .temp_code_i(temp), .event_o(event_o), .event_oe_o(event_oe_o));
  serial_master_model i_serial_master_model (.clock_i(clock_i), .sda_i(sda), .scl_o(m_scl), .sda_oe_o(m_oe));

  always #25 clock_i = ~clock_i;

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Optional pointer write, then word write or word read
  task automatic acc(input logic [6:0] a, input logic sp, input logic [2:0] p, input logic wr,
                     input logic [15:0] w, output logic [15:0] r, output logic ok);
    logic [7:0] q;
    logic       ak;
    ok = 1'b1;
    i_serial_master_model.start();
    if (sp || wr) begin
      i_serial_master_model.xfer({a, 1'b0}, 1'b1, q, ak);
      ok = ~ak;
      i_serial_master_model.xfer({5'h00, p}, 1'b1, q, ak);
      if (wr) begin
        i_serial_master_model.xfer(w[15:8], 1'b1, q, ak);
        i_serial_master_model.xfer(w[7:0], 1'b1, q, ak);
      end
      else i_serial_master_model.start();
    end
    if (!wr) begin
      i_serial_master_model.xfer({a, 1'b1}, 1'b1, q, ak);
      ok = ok & ~ak;
      i_serial_master_model.xfer(8'hff, 1'b0, r[15:8], ak);
      i_serial_master_model.xfer(8'hff, 1'b1, r[7:0], ak);
    end
    i_serial_master_model.stop();
  endtask

  function automatic logic [15:0] exp_temp(input logic [9:0] c, input logic [15:0] up, lo, cr);
    logic signed [10:0] t;
    t = {c[9], c};
    return {t > $signed(cr[12:2]), t > $signed(up[12:2]), t < $signed(lo[12:2]), c[9], c, 2'b00};
  endfunction

  initial begin
    logic [15:0] r, e;
    logic [15:0] up, lo, cr;
    logic [9:0]  corner [4];
    logic [7:0]  q;
    logic        ok, ak;
    logic [6:0]  a;
    corner = '{10'h191, 10'h0c9, 10'h0c8, 10'h013};
    i_serial_master_model.tick(10);
    rst_n_i = 1'b1;
    i_serial_master_model.tick(10);
    a = {TYPE, strap};
    acc(a, 0, 0, 0, 0, r, ok);
    chk("capability", 16'h002f, r);
    acc(a, 1, REG_CONFIG, 0, 0, r, ok);
    chk("config", 16'h0000, r);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      i_serial_master_model.tick(10);
      acc({TYPE, strap ^ 3'(1 << (s % 3))}, 0, 0, 0, 0, r, ok);
      chk("foreign ack", 16'h0000, {15'h0, ok});
      chk("foreign data", 16'hffff, r);
      acc({TYPE, strap}, 0, 0, 0, 0, r, ok);
      chk("own ack", 16'h0001, {15'h0, ok});
    end
    a = {TYPE, strap};
    $display("test address done");
    for (int i = 0; i < 6; i++) begin
      e = 16'($random(seed));
      acc(a, 1, REG_UPPER + 3'(i % 3), 1, e, r, ok);
      acc(a, 1, REG_UPPER + 3'(i % 3), 0, 0, r, ok);
      chk("trip word", e, r);
      acc(a, 0, 0, 0, 0, r, ok);
      chk("repeat read", e, r);
    end
    acc(a, 1, REG_CAPABILITY, 1, 16'h1234, r, ok);
    acc(a, 0, 0, 0, 0, r, ok);
    chk("read-only", 16'h002f, r);
    $display("test registers done");
    up = 16'h0320;
    lo = 16'h0050;
    cr = 16'h0640;
    acc(a, 1, REG_UPPER, 1, up, r, ok);
    acc(a, 1, REG_LOWER, 1, lo, r, ok);
    acc(a, 1, REG_CRITICAL, 1, cr, r, ok);
    for (int i = 0; i < 10; i++) begin
      acc(a, 1, REG_CONFIG, 1, {12'h000, 1'b1, i[0], 2'b00}, r, ok);
      temp = (i < 4) ? corner[i] : 10'($random(seed));
      i_serial_master_model.tick(UPD + 10);
      acc(a, 1, REG_TEMP, 0, 0, r, ok);
      e = exp_temp(temp, up, lo, cr);
      chk("temperature", e, r);
      chk("event", {15'h0, i[0] ? e[15] : |e[15:13]}, {15'h0, event_oe_o});
    end
    temp = 10'h064;
    i_serial_master_model.tick(UPD + 10);
    acc(a, 1, REG_CONFIG, 1, 16'h0029, r, ok);
    chk("event cleared", 16'h0000, {15'h0, event_oe_o});
    temp = 10'h191;
    i_serial_master_model.tick(UPD + 10);
    temp = 10'h064;
    i_serial_master_model.tick(UPD + 10);
    chk("event held", 16'h0001, {15'h0, event_oe_o});
    acc(a, 1, REG_CONFIG, 1, 16'h0029, r, ok);
    chk("event cleared", 16'h0000, {15'h0, event_oe_o});
    $display("test event done");
    acc(a, 1, REG_CAPABILITY, 0, 0, r, ok);
    i_serial_master_model.start();
    i_serial_master_model.xfer({a, 1'b1}, 1'b1, q, ak);
    i_serial_master_model.tick(TMO + 50);
    chk("released", 16'h0000, {15'h0, sda_oe_o});
    i_serial_master_model.stop();
    acc(a, 0, 0, 0, 0, r, ok);
    chk("after timeout", 16'h002f, r);
    $display("test timeout done");
    print_verdict();
  end

  initial begin
    #4ms;
    fail_count++;
    print_verdict();
  end
endmodule

bind thermal_sensor_serial_slave thermal_monitor #(.TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P)) i_thermal_monitor (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .event_o(event_o), .event_oe_o(event_oe_o));
